// file: iomev_merge.sv
// Merge filter keeping the last record written to each queue and its age.
`timescale 1ns/1ns
module iomev_merge (
	input wire logic clk, // Core clock.
	input wire logic rst, // Synchronous reset.
	input wire logic ce, // Clock enable.
	input wire logic [iomev_pkg::REC_BITS-1:0] rec, // Candidate record.
	input wire logic sec, // Candidate queue.
	input wire logic allow, // Candidate may merge at all.
	input wire logic [15:0] window, // Age limit in cycles.
	input wire logic update, // Candidate was written out.
	output logic hit // Candidate duplicates a recent record.
);
	logic [iomev_pkg::REC_BITS-1:0] last_rec [2];
	logic [1:0] last_valid;
	logic [15:0] age [2];

	// Only records seen shortly before count, so slow repeats are still written separately.
	assign hit = allow && last_valid[sec] && last_rec[sec] == rec && age[sec] < window;

	// History per queue; the age saturates rather than wrapping back into the window.
	always_ff @(posedge clk) begin
		if (rst) begin
			last_valid <= 2'h0;
			age[0] <= 16'h0000;
			age[1] <= 16'h0000;
			last_rec[0] <= '0;
			last_rec[1] <= '0;
		end else if (ce) begin
			for (int q = 0; q < 2; q++) begin
				if (update && sec == q[0]) begin
					last_rec[q] <= rec;
					last_valid[q] <= 1'b1;
					age[q] <= 16'h0000;
				end else if (age[q] != 16'hFFFF) begin
					age[q] <= age[q] + 16'h0001;
				end
			end
		end
	end
endmodule : iomev_merge

// file: iomev_outreg.sv
// Output holding register presenting one record to the queue writer.
`timescale 1ns/1ns
module iomev_outreg (
	input wire logic clk, // Core clock.
	input wire logic rst, // Synchronous reset.
	input wire logic ce, // Clock enable.
	input wire logic load, // Take a new record.
	input wire logic [iomev_pkg::REC_BITS-1:0] rec_in, // Record to hold.
	input wire logic sec_in, // Queue of that record.
	input wire logic ready, // Writer accepts.
	output logic valid, // Record is offered.
	output logic [iomev_pkg::REC_BITS-1:0] rec_out, // Held record.
	output logic sec_out // Held queue select.
);
	// Data are only loaded while empty, so they stay stable until accepted.
	always_ff @(posedge clk) begin
		if (rst) begin
			valid <= 1'b0;
			rec_out <= '0;
			sec_out <= 1'b0;
		end else if (ce) begin
			if (load && !valid) begin
				valid <= 1'b1;
				rec_out <= rec_in;
				sec_out <= sec_in;
			end else if (valid && ready) begin
				valid <= 1'b0;
			end
		end
	end
endmodule : iomev_outreg

// file: iomev_pkg.sv
// Package with record layout, register map, types and constants for the event record generator.
package iomev_pkg;

	// Record geometry: one record is 32 bytes, byte 0 in bits [7:0].
	localparam int REC_BYTES = 32;
	localparam int REC_BITS = REC_BYTES * 8;

	// Event numbers.
	localparam logic [7:0] EVT_UUT = 8'h01;
	localparam logic [7:0] EVT_BAD_SID = 8'h02;
	localparam logic [7:0] EVT_STE_FETCH = 8'h03;
	localparam logic [7:0] EVT_BAD_STE = 8'h04;

	// Field positions inside the 256-bit record word.
	localparam int POS_EVT = 0;
	localparam int POS_SSV = 11;
	localparam int POS_SUBSTREAM = 12;
	localparam int POS_SID = 32;
	localparam int POS_REASON = 64;
	localparam int POS_PRIV = 97;
	localparam int POS_INSTR = 98;
	localparam int POS_RNW = 99;
	localparam int POS_NONSECURE_IPA_FLAG = 102;
	localparam int POS_STAGE = 103;
	localparam int POS_CLASS = 104;
	localparam int POS_STALL = 127;
	localparam int POS_ADDR = 128;
	localparam int POS_FETCH = 192;

	// Operation class codes; the last is never emitted.
	localparam logic [1:0] CLASS_CD = 2'h0;
	localparam logic [1:0] CLASS_TTD = 2'h1;
	localparam logic [1:0] CLASS_IN = 2'h2;
	localparam logic [1:0] CLASS_RSVD = 2'h3;

	// First-level span limits.
	localparam logic [4:0] SPAN_MAX = 5'h0C;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TABLE_NS = 8'h04;
	localparam logic [7:0] REG_TABLE_S = 8'h08;
	localparam logic [7:0] REG_MERGE_WIN = 8'h0C;
	localparam logic [7:0] REG_COUNT = 8'h10;

	// Control register fields.
	localparam int CTRL_XLATE_EN = 0;
	localparam int CTRL_EQ_EN = 1;
	localparam int CTRL_REC_INV = 3;
	localparam int CTRL_WIDTH = 5;

	// Reset values.
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [10:0] TABLE_RESET = 11'h000;
	localparam logic [15:0] MERGE_WIN_RESET = 16'h0040;

	// Operation kinds presented by upstream lookup logic.
	typedef enum logic [1:0] {
		KIND_UUT = 2'h0,
		KIND_SID = 2'h1,
		KIND_GEN = 2'h3
	} iomev_kind_type;

	// Controller states.
	typedef enum logic {
		ST_IDLE = 1'h0,
		ST_CHECK = 1'h1
	} iomev_state_type;

	// Stream table configuration of one security state.
	typedef struct packed {
		logic [3:0] split;
		logic two_level;
		logic [5:0] log2_size;
	} iomev_tbl_type;

	// One fault report from upstream.
	typedef struct packed {
		iomev_kind_type kind;
		logic [7:0] evt_num;
		logic secure;
		logic [31:0] stream_id;
		logic substream_valid;
		logic [19:0] substream_id;
		logic read_not_write;
		logic priv_in;
		logic instr_in;
		logic priv_flag;
		logic instr_flag;
		logic [63:0] fault_input_address;
		logic fault_stage;
		logic [1:0] op_class;
		logic stage1_ns;
		logic fetch_valid;
		logic [63:0] fetch_addr;
		logic [15:0] reason;
		logic stall;
		logic merge_enable;
		logic [4:0] first_level_span;
	} iomev_req_type;

endpackage : iomev_pkg

// file: iomev_qw_model.sv
// Queue writer model that takes records at a random pace and checks that each offer holds.
`timescale 1ns/1ns
module iomev_qw_model (
	input wire logic clk, // Core clock.
	input wire logic rst, // Synchronous reset.
	input wire logic valid, // Record offered.
	input wire logic secure, // Queue select.
	input wire logic [iomev_pkg::REC_BITS-1:0] record, // Offered record.
	output logic ready, // Record accepted.
	output logic [iomev_pkg::REC_BITS-1:0] got_rec, // Last accepted record.
	output logic got_sec, // Queue of that record.
	output int n_got, // Accepted records.
	output int n_bad // Offers that moved or vanished before acceptance.
);
	logic [iomev_pkg::REC_BITS:0] held;
	logic waiting;
	// Random back-pressure is what exposes an offer that changes while it waits.
	always @(posedge clk) begin
		if (rst) begin
			ready <= 1'b0;
			n_got <= 0;
			n_bad <= 0;
			waiting <= 1'b0;
		end else begin
			if (waiting && (valid !== 1'b1 || {secure, record} !== held)) n_bad <= n_bad + 1;
			if (valid === 1'b1 && ready) begin
				got_rec <= record;
				got_sec <= secure;
				n_got <= n_got + 1;
			end
			waiting <= valid === 1'b1 && !ready;
			held <= {secure, record};
			ready <= ($urandom % 3) != 0;
		end
	end
endmodule : iomev_qw_model

// file: iomev_top.sv
// Event record generator: builds, filters, merges and hands records to the queue writer.
//
// Contract
// - Records are 32 bytes, little-endian.
// - Record goes to the stream's security queue.
// - Read/write flag: 0 write, 1 read.
// - Privilege flag after overrides, 1 privileged.
// - Instruction flag after overrides, 1 instruction.
// - Full 64-bit input address kept unchanged.
// - Substream valid flag marks substream field.
// - Fault stage: 0 stage 1, 1 stage 2.
// - Class codes 00, 01, 10; never 11.
// - Non-secure IPA bit only secure stage-2.
// - Fetch address is the structure entry address.
// - Undefined record parts are written zero.
// - Merge only when stream merge enable set.
// - Merge identical events close in time.
// - Never merge stalled events.
// - Pre-lookup event types may always merge.
// - Slow repeats get separate records.
// - Unsupported transaction is event 0x01 with reason.
// - That event reports attributes before overrides.
// - Unsupported transaction recorded with translation off.
// - Bad stream event 0x02 when identifier too large.
// - Two-level span checks also raise it.
// - Deliver only to writable queue, else drop; a stalled event is held until its queue is writable.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
module iomev_top (
	input wire logic CLK, // Core clock, 100 MHz.
	input wire logic RST, // Synchronous reset, active high.
	input wire logic CE, // Clock enable; low freezes all state.
	input wire logic WB_CYC, // Wishbone cycle.
	input wire logic WB_STB, // Wishbone strobe.
	input wire logic WB_WE, // Wishbone write enable.
	input wire logic [7:0] WB_ADR, // Wishbone byte address.
	input wire logic [3:0] WB_SEL, // Wishbone byte selects.
	input wire logic [31:0] WB_DAT_I, // Wishbone write data.
	output logic [31:0] WB_DAT_O, // Wishbone read data.
	output logic WB_ACK, // Wishbone acknowledge.
	input wire logic IN_VALID, // Fault report offered.
	output logic IN_READY, // Fault report taken.
	input wire iomev_pkg::iomev_req_type IN_REQ, // Fault report contents.
	input wire logic [1:0] QUEUE_FULL, // Queue full, index 1 secure.
	input wire logic [1:0] QUEUE_ABORT, // Unacknowledged queue abort error.
	output logic OUT_VALID, // Record offered to writer.
	input wire logic OUT_READY, // Writer accepts record.
	output logic OUT_SECURE, // Record belongs on secure queue.
	output logic [iomev_pkg::REC_BITS-1:0] OUT_RECORD // Record, byte 0 in bits 7:0.
);
	logic [iomev_pkg::CTRL_WIDTH-1:0] ctrl;
	iomev_pkg::iomev_tbl_type tbl [2];
	logic [15:0] merge_win;
	logic [15:0] cnt_written;
	logic [15:0] cnt_dropped;
	iomev_pkg::iomev_state_type state;
	iomev_pkg::iomev_req_type rq;
	logic [iomev_pkg::REC_BITS-1:0] rec;
	logic translation_enable;
	logic [1:0] event_queue_enable;
	logic [1:0] record_invalid_stream_enable;
	logic gen_ok;
	logic mergeable;
	logic hit;
	logic writable;
	logic load;
	logic merged;
	logic dropped;
	logic wb_req;

	assign translation_enable = ctrl[iomev_pkg::CTRL_XLATE_EN];
	assign event_queue_enable = ctrl[iomev_pkg::CTRL_EQ_EN +: 2];
	assign record_invalid_stream_enable = ctrl[iomev_pkg::CTRL_REC_INV +: 2];

	// Applies Wishbone byte selects to a register word.
	function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : sel_merge

	// Out-of-range stream identifier test for one table configuration.
	function automatic logic bad_stream(input logic [31:0] sid, input iomev_pkg::iomev_tbl_type t,
		input logic [4:0] span);
		logic [31:0] low;
		logic [31:0] lim;
		logic bad;
		low = sid & ((32'h1 << t.split) - 32'h1);
		lim = 32'h1 << (span - 5'h01);
		bad = (sid >> t.log2_size) != 32'h0;
		if (t.two_level) begin
			bad = bad || span == 5'h00 || span > iomev_pkg::SPAN_MAX;
			bad = bad || span > ({1'b0, t.split} + 5'h01) || low >= lim;
		end
		return bad;
	endfunction : bad_stream

	// Packs one report into a record; every field not named stays zero.
	function automatic logic [iomev_pkg::REC_BITS-1:0] build(input iomev_pkg::iomev_req_type r);
		logic [iomev_pkg::REC_BITS-1:0] w;
		w = '0;
		w[iomev_pkg::POS_SID +: 32] = r.stream_id;
		w[iomev_pkg::POS_SSV] = r.substream_valid;
		if (r.substream_valid) begin
			w[iomev_pkg::POS_SUBSTREAM +: 20] = r.substream_id;
		end
		case (r.kind)
			iomev_pkg::KIND_UUT: begin
				w[iomev_pkg::POS_EVT +: 8] = iomev_pkg::EVT_UUT;
				w[iomev_pkg::POS_REASON +: 16] = r.reason;
				w[iomev_pkg::POS_RNW] = r.read_not_write;
				w[iomev_pkg::POS_PRIV] = r.priv_in;
				w[iomev_pkg::POS_INSTR] = r.instr_in;
				w[iomev_pkg::POS_ADDR +: 64] = r.fault_input_address;
			end
			iomev_pkg::KIND_SID: begin
				w[iomev_pkg::POS_EVT +: 8] = iomev_pkg::EVT_BAD_SID;
			end
			default: begin
				w[iomev_pkg::POS_EVT +: 8] = r.evt_num;
				w[iomev_pkg::POS_REASON +: 16] = r.reason;
				w[iomev_pkg::POS_RNW] = r.read_not_write;
				w[iomev_pkg::POS_PRIV] = r.priv_flag;
				w[iomev_pkg::POS_INSTR] = r.instr_flag;
				w[iomev_pkg::POS_STAGE] = r.fault_stage;
				w[iomev_pkg::POS_CLASS +: 2] = r.op_class;
				w[iomev_pkg::POS_NONSECURE_IPA_FLAG] = r.secure && r.fault_stage && r.stage1_ns;
				w[iomev_pkg::POS_STALL] = r.stall;
				w[iomev_pkg::POS_ADDR +: 64] = r.fault_input_address;
				if (r.fetch_valid) begin
					w[iomev_pkg::POS_FETCH +: 64] = r.fetch_addr;
				end
			end
		endcase
		return w;
	endfunction : build

	// Decides whether an incoming report produces a record at all.
	always_comb begin
		case (IN_REQ.kind)
			iomev_pkg::KIND_UUT: gen_ok = 1'b1;
			iomev_pkg::KIND_SID: gen_ok = translation_enable && record_invalid_stream_enable[IN_REQ.secure]
				&& bad_stream(IN_REQ.stream_id, tbl[IN_REQ.secure], IN_REQ.first_level_span);
			default: gen_ok = translation_enable && IN_REQ.op_class != iomev_pkg::CLASS_RSVD;
		endcase
	end

	// Stalled events never merge; otherwise the stream's enable or a pre-lookup type allows it.
	assign mergeable = !rq.stall && (rq.merge_enable || rq.kind != iomev_pkg::KIND_GEN
		|| rq.evt_num == iomev_pkg::EVT_STE_FETCH || rq.evt_num == iomev_pkg::EVT_BAD_STE);

	// Queue writable: enabled, not full, no pending abort error.
	assign writable = event_queue_enable[rq.secure] && !QUEUE_FULL[rq.secure] && !QUEUE_ABORT[rq.secure];

	// Outcome of the check cycle; a busy output register simply waits.
	assign merged = state == iomev_pkg::ST_CHECK && !OUT_VALID && hit;
	assign load = state == iomev_pkg::ST_CHECK && !OUT_VALID && !hit && writable;
	assign dropped = state == iomev_pkg::ST_CHECK && !OUT_VALID && !hit && !writable && !rq.stall;

	// Controller: take a report, build its record, then merge, deliver, drop or hold.
	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= iomev_pkg::ST_IDLE;
			IN_READY <= 1'b0;
			rq <= '0;
			rec <= '0;
		end else if (CE) begin
			case (state)
				iomev_pkg::ST_IDLE: begin
					IN_READY <= 1'b1;
					if (IN_VALID && IN_READY && gen_ok) begin
						rq <= IN_REQ;
						rec <= build(IN_REQ);
						IN_READY <= 1'b0;
						state <= iomev_pkg::ST_CHECK;
					end
				end
				iomev_pkg::ST_CHECK: begin
					// A stalled event waits here, so back-pressure reaches upstream.
					if (merged || load || dropped) begin
						IN_READY <= 1'b1;
						state <= iomev_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= iomev_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Merge history, refreshed only by records actually written out.
	iomev_merge u_merge (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.rec(rec),
		.sec(rq.secure),
		.allow(mergeable),
		.window(merge_win),
		.update(load),
		.hit(hit)
	);

	// Record handed over on its security state's queue select.
	iomev_outreg u_out (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.load(load),
		.rec_in(rec),
		.sec_in(rq.secure),
		.ready(OUT_READY),
		.valid(OUT_VALID),
		.rec_out(OUT_RECORD),
		.sec_out(OUT_SECURE)
	);

	// Activity counters for software; both wrap.
	always_ff @(posedge CLK) begin
		if (RST) begin
			cnt_written <= 16'h0000;
			cnt_dropped <= 16'h0000;
		end else if (CE) begin
			if (load) begin
				cnt_written <= cnt_written + 16'h0001;
			end
			if (dropped) begin
				cnt_dropped <= cnt_dropped + 16'h0001;
			end
		end
	end

	// Wishbone slave: one wait state, ack for one cycle, unmapped reads return zero.
	assign wb_req = WB_CYC && WB_STB && !WB_ACK;

	always_ff @(posedge CLK) begin
		if (RST) begin
			WB_ACK <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			ctrl <= iomev_pkg::CTRL_RESET;
			tbl[0] <= iomev_pkg::TABLE_RESET;
			tbl[1] <= iomev_pkg::TABLE_RESET;
			merge_win <= iomev_pkg::MERGE_WIN_RESET;
		end else if (CE) begin
			WB_ACK <= wb_req;
			WB_DAT_O <= 32'h00000000;
			if (wb_req) begin
				case (WB_ADR)
					iomev_pkg::REG_CTRL: begin
						WB_DAT_O <= {27'h0, ctrl};
						if (WB_WE) begin
							ctrl <= (iomev_pkg::CTRL_WIDTH)'(sel_merge({27'h0, ctrl}, WB_DAT_I, WB_SEL));
						end
					end
					iomev_pkg::REG_TABLE_NS: begin
						WB_DAT_O <= {21'h0, tbl[0]};
						if (WB_WE) begin
							tbl[0] <= 11'(sel_merge({21'h0, tbl[0]}, WB_DAT_I, WB_SEL));
						end
					end
					iomev_pkg::REG_TABLE_S: begin
						WB_DAT_O <= {21'h0, tbl[1]};
						if (WB_WE) begin
							tbl[1] <= 11'(sel_merge({21'h0, tbl[1]}, WB_DAT_I, WB_SEL));
						end
					end
					iomev_pkg::REG_MERGE_WIN: begin
						WB_DAT_O <= {16'h0, merge_win};
						if (WB_WE) begin
							merge_win <= 16'(sel_merge({16'h0, merge_win}, WB_DAT_I, WB_SEL));
						end
					end
					iomev_pkg::REG_COUNT: begin
						WB_DAT_O <= {cnt_dropped, cnt_written};
					end
					default: begin
						WB_DAT_O <= 32'h00000000;
					end
				endcase
			end
		end
	end

	// Checks on the produced records and their delivery.
	property p_uut_number;
		@(posedge CLK) disable iff (RST)
		load && CE && rq.kind == iomev_pkg::KIND_UUT |=> OUT_RECORD[7:0] == iomev_pkg::EVT_UUT;
	endproperty
	a_uut_number: assert property (p_uut_number) else $error("Unsupported transaction record lacks 0x01.");

	property p_rnw;
		@(posedge CLK) disable iff (RST)
		load && CE && rq.kind != iomev_pkg::KIND_SID |=> OUT_RECORD[iomev_pkg::POS_RNW] == $past(rq.read_not_write);
	endproperty
	a_rnw: assert property (p_rnw) else $error("Read/write flag differs from the request.");

	property p_class;
		@(posedge CLK) disable iff (RST)
		OUT_VALID |-> OUT_RECORD[iomev_pkg::POS_CLASS +: 2] != iomev_pkg::CLASS_RSVD;
	endproperty
	a_class: assert property (p_class) else $error("Reserved class code emitted.");

	property p_nonsecure_ipa_flag;
		@(posedge CLK) disable iff (RST)
		OUT_VALID && (!OUT_SECURE || !OUT_RECORD[iomev_pkg::POS_STAGE]) |-> !OUT_RECORD[iomev_pkg::POS_NONSECURE_IPA_FLAG];
	endproperty
	a_nonsecure_ipa_flag: assert property (p_nonsecure_ipa_flag) else $error("Non-secure IPA bit set outside secure stage 2.");

	property p_hold;
		@(posedge CLK) disable iff (RST)
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_RECORD) && $stable(OUT_SECURE);
	endproperty
	a_hold: assert property (p_hold) else $error("Offered record changed before acceptance.");

	property p_writable;
		@(posedge CLK) disable iff (RST)
		$rose(OUT_VALID) |-> $past(writable);
	endproperty
	a_writable: assert property (p_writable) else $error("Record delivered to an unwritable queue.");

	property p_queue;
		@(posedge CLK) disable iff (RST)
		load && CE |=> OUT_VALID && OUT_SECURE == $past(rq.secure);
	endproperty
	a_queue: assert property (p_queue) else $error("Record steered to the wrong queue.");

	property p_bad_sid_enable;
		@(posedge CLK) disable iff (RST)
		load && rq.kind == iomev_pkg::KIND_SID |-> record_invalid_stream_enable[rq.secure];
	endproperty
	a_bad_sid_enable: assert property (p_bad_sid_enable) else $error("Bad stream record while disabled.");

	property p_xlate_off;
		@(posedge CLK) disable iff (RST)
		state == iomev_pkg::ST_IDLE && IN_VALID && IN_READY && CE && !translation_enable
			&& IN_REQ.kind == iomev_pkg::KIND_UUT ##1 CE |-> state == iomev_pkg::ST_CHECK;
	endproperty
	a_xlate_off: assert property (p_xlate_off) else $error("Unsupported transaction lost while disabled.");

	property p_no_stall_merge;
		@(posedge CLK) disable iff (RST)
		merged |-> !rq.stall && (rq.merge_enable || rq.kind != iomev_pkg::KIND_GEN
			|| rq.evt_num == iomev_pkg::EVT_STE_FETCH || rq.evt_num == iomev_pkg::EVT_BAD_STE);
	endproperty
	a_no_stall_merge: assert property (p_no_stall_merge) else $error("Event merged against its settings.");

endmodule : iomev_top

// file: tb_top.sv
// Self-checking bench for the event record generator.
`timescale 1ns/1ns
module tb_top;
	logic CLK, RST, CE, WB_CYC, WB_STB, WB_WE, WB_ACK, IN_VALID, IN_READY, OUT_VALID, OUT_READY, OUT_SECURE;
	logic [7:0] WB_ADR;
	logic [3:0] WB_SEL;
	logic [31:0] WB_DAT_I, WB_DAT_O;
	logic [1:0] QUEUE_FULL, QUEUE_ABORT;
	logic [iomev_pkg::REC_BITS-1:0] OUT_RECORD, got_rec;
	logic got_sec;
	iomev_pkg::iomev_req_type IN_REQ, r;
	int n_got, n_bad, n_fail, compares, n_seen;
	logic [31:0] sid_tab [6] = '{32'h100, 32'hFF, 32'h5, 32'h6, 32'h14, 32'h13};
	logic [4:0] span_tab [6] = '{5'h0, 5'h0, 5'h0, 5'h6, 5'h3, 5'h3};

	iomev_top uut (.CLK(CLK), .RST(RST), .CE(CE), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
		.WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK),
		.IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_REQ(IN_REQ), .QUEUE_FULL(QUEUE_FULL),
		.QUEUE_ABORT(QUEUE_ABORT), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_SECURE(OUT_SECURE),
		.OUT_RECORD(OUT_RECORD));
	iomev_qw_model writer (.clk(CLK), .rst(RST), .valid(OUT_VALID), .secure(OUT_SECURE), .record(OUT_RECORD),
		.ready(OUT_READY), .got_rec(got_rec), .got_sec(got_sec), .n_got(n_got), .n_bad(n_bad));

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_rec(input logic [iomev_pkg::REC_BITS-1:0] got, input logic [iomev_pkg::REC_BITS-1:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: record %h, expected %h", $time, got, exp);
		end
	endtask : cmp_rec

	// One classic cycle: hold everything until ack is seen, then release for an idle cycle.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] dq);
		int i;
		WB_CYC <= 1'b1;
		WB_STB <= 1'b1;
		WB_WE <= we;
		WB_ADR <= a;
		WB_DAT_I <= d;
		WB_SEL <= 4'hF;
		i = 0;
		do begin
			@(posedge CLK);
			i++;
		end while (WB_ACK !== 1'b1 && i < 100);
		if (WB_ACK !== 1'b1) n_fail++;
		dq = WB_DAT_O;
		WB_CYC <= 1'b0;
		WB_STB <= 1'b0;
		@(posedge CLK);
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		wb(1'b0, a, 32'h0, v);
		cmp_val(v, e);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		wb(1'b1, a, d, v);
	endtask : wr

	// Random report; event numbers avoid the always-mergeable fetch and entry codes.
	function automatic iomev_pkg::iomev_req_type rnd(input iomev_pkg::iomev_kind_type k, input logic s);
		logic [255:0] t;
		iomev_pkg::iomev_req_type x;
		t = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		x = t[$bits(x)-1:0];
		x.kind = k;
		x.secure = s;
		x.evt_num = {4'h1, x.evt_num[3:0]};
		x.op_class = 2'($urandom % 3);
		x.stall = 1'b0;
		x.merge_enable = 1'b0;
		return x;
	endfunction : rnd

	function automatic logic [iomev_pkg::REC_BITS-1:0] exp_rec(input iomev_pkg::iomev_req_type x);
		logic [iomev_pkg::REC_BITS-1:0] e;
		e = '0;
		e[iomev_pkg::POS_SSV] = x.substream_valid;
		if (x.substream_valid) e[iomev_pkg::POS_SUBSTREAM+:20] = x.substream_id;
		e[iomev_pkg::POS_SID+:32] = x.stream_id;
		if (x.kind == iomev_pkg::KIND_SID) begin
			e[7:0] = iomev_pkg::EVT_BAD_SID;
			return e;
		end
		e[iomev_pkg::POS_REASON+:16] = x.reason;
		e[iomev_pkg::POS_RNW] = x.read_not_write;
		e[iomev_pkg::POS_ADDR+:64] = x.fault_input_address;
		if (x.kind == iomev_pkg::KIND_UUT) begin
			e[7:0] = iomev_pkg::EVT_UUT;
			e[iomev_pkg::POS_PRIV] = x.priv_in;
			e[iomev_pkg::POS_INSTR] = x.instr_in;
			return e;
		end
		e[7:0] = x.evt_num;
		e[iomev_pkg::POS_PRIV] = x.priv_flag;
		e[iomev_pkg::POS_INSTR] = x.instr_flag;
		e[iomev_pkg::POS_STAGE] = x.fault_stage;
		e[iomev_pkg::POS_CLASS+:2] = x.op_class;
		e[iomev_pkg::POS_NONSECURE_IPA_FLAG] = x.secure & x.fault_stage & x.stage1_ns;
		e[iomev_pkg::POS_STALL] = x.stall;
		if (x.fetch_valid) e[iomev_pkg::POS_FETCH+:64] = x.fetch_addr;
		return e;
	endfunction : exp_rec

	task automatic send(input iomev_pkg::iomev_req_type x);
		int i;
		IN_REQ <= x;
		IN_VALID <= 1'b1;
		i = 0;
		do begin
			@(posedge CLK);
			i++;
		end while (IN_READY !== 1'b1 && i < 500);
		if (IN_READY !== 1'b1) n_fail++;
		IN_VALID <= 1'b0;
	endtask : send

	task automatic expect_rec(input iomev_pkg::iomev_req_type x);
		int i;
		i = 0;
		while (n_got == n_seen && i < 500) begin
			@(posedge CLK);
			i++;
		end
		if (n_got == n_seen) n_fail++;
		n_seen++;
		cmp_rec(got_rec, exp_rec(x));
		cmp_val(32'(got_sec), 32'(x.secure));
	endtask : expect_rec

	// A due record would have reached the writer well inside this span.
	task automatic expect_none();
		repeat (12) @(posedge CLK);
		cmp_val(32'(n_got - n_seen), 32'h0);
	endtask : expect_none

	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	// Cuts a hang short well beyond the few hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge CLK);
		n_fail++;
		final_report();
	end

	initial begin
		void'($urandom(1456));
		{RST, CE} = 2'h3;
		{WB_CYC, WB_STB, WB_WE, WB_ADR, WB_SEL, WB_DAT_I} = '0;
		{IN_VALID, IN_REQ, QUEUE_FULL, QUEUE_ABORT} = '0;
		{n_fail, compares, n_seen} = '0;
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rd(iomev_pkg::REG_CTRL, 32'(iomev_pkg::CTRL_RESET));
		rd(iomev_pkg::REG_TABLE_NS, 32'(iomev_pkg::TABLE_RESET));
		rd(iomev_pkg::REG_MERGE_WIN, 32'(iomev_pkg::MERGE_WIN_RESET));
		rd(8'h20, 32'h0);
		wr(iomev_pkg::REG_COUNT, 32'hFFFFFFFF);
		rd(iomev_pkg::REG_COUNT, 32'h0);
		// Queues open but translation off: only the unsupported transaction may appear.
		wr(iomev_pkg::REG_CTRL, 32'h6);
		r = rnd(iomev_pkg::KIND_UUT, 1'b1);
		send(r);
		expect_rec(r);
		r = rnd(iomev_pkg::KIND_GEN, 1'b0);
		send(r);
		expect_none();
		wr(iomev_pkg::REG_CTRL, 32'h1F);
		for (int i = 0; i < 9; i++) begin
			r = rnd(iomev_pkg::KIND_GEN, i[1]);
			r.op_class = 2'(i % 3);
			send(r);
			expect_rec(r);
		end
		r.op_class = iomev_pkg::CLASS_RSVD;
		send(r);
		expect_none();
		// Repeat each event: merged only where the type, enable, stall and age allow it.
		for (int m = 0; m < 5; m++) begin
			r = rnd(m == 0 ? iomev_pkg::KIND_UUT : iomev_pkg::KIND_GEN, 1'b0);
			r.merge_enable = m >= 2;
			r.stall = m == 3;
			send(r);
			expect_rec(r);
			if (m == 4) repeat (80) @(posedge CLK);
			send(r);
			if (m == 0 || m == 2)
				expect_none();
			else
				expect_rec(r);
		end
		wr(iomev_pkg::REG_TABLE_NS, 32'h8);
		wr(iomev_pkg::REG_TABLE_S, 32'h250);
		for (int b = 0; b < 6; b++) begin
			r = rnd(iomev_pkg::KIND_SID, b >= 2);
			r.stream_id = sid_tab[b];
			r.first_level_span = span_tab[b];
			send(r);
			if (b == 1 || b == 5)
				expect_none();
			else
				expect_rec(r);
		end
		// Clock enable low freezes the controller, so a report offered then is never taken.
		CE <= 1'b0;
		r = rnd(iomev_pkg::KIND_GEN, 1'b0);
		send(r);
		expect_none();
		CE <= 1'b1;
		// Unwritable queues drop ordinary events but keep a stalled one until they open.
		QUEUE_FULL <= 2'h1;
		r = rnd(iomev_pkg::KIND_GEN, 1'b0);
		send(r);
		expect_none();
		QUEUE_ABORT <= 2'h2;
		r = rnd(iomev_pkg::KIND_GEN, 1'b1);
		send(r);
		expect_none();
		r.stall = 1'b1;
		send(r);
		expect_none();
		QUEUE_ABORT <= 2'h0;
		QUEUE_FULL <= 2'h0;
		expect_rec(r);
		rd(iomev_pkg::REG_COUNT, {16'h2, 16'(n_seen)});
		cmp_val(32'(n_bad), 32'h0);
		final_report();
	end
endmodule : tb_top
